// [rtl/epp_pkg.sv]
// package for the extended parallel port register block
// assumes a synchronous host access port and one 50 MHz clock
package epp_pkg;
  // ****************************************
  // register offsets (11-bit host offset)
  // ****************************************
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STATUS = 11'h001;
  localparam logic [10:0] OFS_CONTROL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CFG_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CONTROL_RST = 6'h00;
  localparam logic [4:0] EXT_CTRL_RST = 5'h05;
  localparam logic [7:0] CFG_A_VALUE = 8'h10;
  localparam int FIFO_DEPTH = 16;
  localparam int TX_FREE_THRESHOLD = 8;
  localparam int RX_FILL_THRESHOLD = 8;
  // ****************************************
  // port modes
  // ****************************************
  typedef enum logic [2:0] {
    EPP_MODE_STD = 3'h0,
    EPP_MODE_BIDIR = 3'h1,
    EPP_MODE_FIFO_STD = 3'h2,
    EPP_MODE_ECP = 3'h3,
    EPP_MODE_EPP = 3'h4,
    EPP_MODE_RSVD = 3'h5,
    EPP_MODE_TEST = 3'h6,
    EPP_MODE_CFG = 3'h7
  } epp_mode_t;
  // peripheral status inputs
  typedef struct packed {
    logic busy;
    logic ack;
    logic paper_error;
    logic select;
    logic fault;
  } epp_status_t;
  // control line outputs
  typedef struct packed {
    logic select_in;
    logic initialise;
    logic autofeed;
    logic strobe;
  } epp_ctrl_lines_t;
endpackage

// [rtl/epp_regs.sv]
// extended parallel port host registers, shared fifo and interrupt control
// assumes host strobes are synchronous one-cycle pulses; the line handshake
// engine outside drains and fills the fifo through the link_* ports
`timescale 1ns/1ns
module epp_regs
  import epp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter logic [2:0] IRQ_CODE = 3'h0,
  parameter logic [2:0] DMA_CODE = 3'h0
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [10:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  output logic [7:0] host_rdata,
  input wire logic dma_ack,
  input wire logic dma_terminal_count,
  output logic dma_request,
  output logic irq_out,
  input wire logic irq_line_level,
  input wire epp_pkg::epp_status_t line_status,
  output epp_pkg::epp_ctrl_lines_t ctrl_lines,
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe,
  output logic [8:0] link_tx_data,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_valid,
  output logic link_rx_ready,
  output epp_pkg::epp_mode_t port_mode,
  output logic port_reverse
);
  import epp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] port_data_latch, next_port_data_latch;
  logic [5:0] line_control_port, next_line_control_port;
  epp_mode_t mode, next_mode;
  logic fault_interrupt_mask, next_fault_interrupt_mask;
  logic dma_enable_bit, next_dma_enable_bit;
  logic service_interrupt_bit, next_service_interrupt_bit;
  logic [8:0] fifo_mem [DEPTH];
  logic [8:0] next_fifo_mem [DEPTH];
  logic [AW-1:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
  logic [AW:0] count, next_count;
  logic [7:0] last_byte, next_last_byte;
  logic ack_prev, next_ack_prev;
  logic fault_prev, next_fault_prev;
  logic irq_pulse, next_irq_pulse;
  logic [7:0] rdata, next_rdata;

  logic fifo_full, fifo_empty, direction, push, pop;
  logic [8:0] push_word;
  logic wr_data, wr_ctrl, wr_fifo, wr_ecr, rd_fifo, dma_wr, dma_rd;
  logic ack_rise, fault_fall;

  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    fifo_full = (count == (AW+1)'(DEPTH));
    fifo_empty = (count == '0);
    direction = line_control_port[5];
    if (mode == EPP_MODE_STD || mode == EPP_MODE_FIFO_STD)
    begin
      direction = 1'b0;
    end
    // strobes act only on enabled edges; the registers freeze otherwise
    wr_data = host_write_strobe && host_addr == OFS_DATA;
    wr_ctrl = host_write_strobe && host_addr == OFS_CONTROL;
    wr_fifo = host_write_strobe && host_addr == OFS_FIFO;
    wr_ecr = host_write_strobe && host_addr == OFS_EXT_CTRL;
    rd_fifo = host_read_strobe && host_addr == OFS_FIFO;
    dma_wr = dma_ack && !direction;
    dma_rd = dma_ack && direction;
  end

  // ****************************************
  // fifo source and sink select
  // ****************************************
  always_comb
  begin
    push = 1'b0;
    pop = 1'b0;
    push_word = {1'b0, host_wdata};
    link_tx_valid = 1'b0;
    link_rx_ready = 1'b0;
    unique case (mode)
      EPP_MODE_FIFO_STD:
      begin
        push = (wr_fifo || dma_wr) && !fifo_full;
        link_tx_valid = !fifo_empty;
        pop = link_tx_valid && link_tx_ready;
      end
      EPP_MODE_ECP:
      begin
        if (!direction)
        begin
          push = (wr_fifo || dma_wr || wr_data) && !fifo_full;
          push_word = {wr_data, host_wdata};
          link_tx_valid = !fifo_empty;
          pop = link_tx_valid && link_tx_ready;
        end
        else
        begin
          link_rx_ready = !fifo_full;
          push = link_rx_valid && !fifo_full;
          push_word = {1'b0, link_rx_data};
          pop = (rd_fifo || dma_rd) && !fifo_empty;
        end
      end
      EPP_MODE_TEST:
      begin
        push = (wr_fifo || dma_wr) && !fifo_full;
        pop = (rd_fifo || dma_rd) && !fifo_empty;
      end
      default:
      begin
        push = 1'b0;
      end
    endcase
    link_tx_data = fifo_mem[rd_ptr];
  end

  // ****************************************
  // line edge detect
  // ****************************************
  always_comb
  begin
    next_ack_prev = line_status.ack;
    next_fault_prev = line_status.fault;
    ack_rise = line_status.ack && !ack_prev;
    fault_fall = fault_prev && !line_status.fault;
  end

  // both lines idle high, so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_prev <= 1'b1;
      fault_prev <= 1'b1;
    end
    else if (clk_en)
    begin
      ack_prev <= next_ack_prev;
      fault_prev <= next_fault_prev;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_port_data_latch = port_data_latch;
    next_line_control_port = line_control_port;
    next_mode = mode;
    next_fault_interrupt_mask = fault_interrupt_mask;
    next_dma_enable_bit = dma_enable_bit;
    next_service_interrupt_bit = service_interrupt_bit;
    next_fifo_mem = fifo_mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    next_last_byte = last_byte;
    next_irq_pulse = 1'b0;
    next_rdata = rdata;

    // the latch only takes writes in the plain port modes
    if (wr_data && (mode == EPP_MODE_STD || mode == EPP_MODE_BIDIR))
    begin
      next_port_data_latch = host_wdata;
    end
    if (wr_ctrl)
    begin
      next_line_control_port = host_wdata[5:0];
    end

    // fifo storage
    if (push)
    begin
      next_fifo_mem[wr_ptr] = push_word;
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_last_byte = fifo_mem[rd_ptr][7:0];
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    // host read data
    if (host_read_strobe)
    begin
      unique case (host_addr)
        OFS_DATA: next_rdata = port_data_lines_in;
        OFS_STATUS: next_rdata = {!line_status.busy, line_status.ack,
          line_status.paper_error, line_status.select, line_status.fault,
          3'h0};
        OFS_CONTROL: next_rdata = {2'h0, line_control_port};
        OFS_FIFO:
        begin
          if (mode == EPP_MODE_CFG)
          begin
            next_rdata = CFG_A_VALUE;
          end
          else if (pop)
          begin
            next_rdata = fifo_mem[rd_ptr][7:0];
          end
          else
          begin
            next_rdata = last_byte;
          end
        end
        OFS_CFG_B: next_rdata = (mode == EPP_MODE_CFG) ?
          {1'b0, irq_line_level, IRQ_CODE, DMA_CODE} : 8'h00;
        OFS_EXT_CTRL: next_rdata = {mode, fault_interrupt_mask, dma_enable_bit,
          service_interrupt_bit, fifo_full, fifo_empty};
        default: next_rdata = 8'h00;
      endcase
    end

    // interrupt sources
    if (line_control_port[4] && ack_rise)
    begin
      next_irq_pulse = 1'b1;
    end
    if (!fault_interrupt_mask && fault_fall)
    begin
      next_irq_pulse = 1'b1;
    end

    // extended control
    if (wr_ecr)
    begin
      next_mode = epp_mode_t'(host_wdata[7:5]);
      next_fault_interrupt_mask = host_wdata[4];
      next_dma_enable_bit = host_wdata[3];
      next_service_interrupt_bit = host_wdata[2];
      if (fault_interrupt_mask && !host_wdata[4] && !line_status.fault)
      begin
        next_irq_pulse = 1'b1;
      end
    end
    // the plain port modes 000 and 001 drop whatever is still queued
    if (mode == EPP_MODE_STD || mode == EPP_MODE_BIDIR)
    begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_count = '0;
    end

    // service events; act only while the registered bit is clear, so a software clear wins its cycle
    if (!service_interrupt_bit)
    begin
      if (dma_enable_bit)
      begin
        if (dma_ack && dma_terminal_count)
        begin
          next_service_interrupt_bit = 1'b1;
          next_irq_pulse = 1'b1;
        end
      end
      else if (!direction && (AW+1)'(DEPTH) - count >= (AW+1)'(TX_FREE_THRESHOLD))
      begin
        next_service_interrupt_bit = 1'b1;
        next_irq_pulse = 1'b1;
      end
      else if (direction && count >= (AW+1)'(RX_FILL_THRESHOLD))
      begin
        next_service_interrupt_bit = 1'b1;
        next_irq_pulse = 1'b1;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_data_latch <= DATA_RST;
      line_control_port <= CONTROL_RST;
      mode <= EPP_MODE_STD;
      fault_interrupt_mask <= EXT_CTRL_RST[2];
      dma_enable_bit <= EXT_CTRL_RST[1];
      service_interrupt_bit <= EXT_CTRL_RST[0];
      fifo_mem <= '{default: '0};
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
      last_byte <= 8'h00;
      irq_pulse <= 1'b0;
      rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      port_data_latch <= next_port_data_latch;
      line_control_port <= next_line_control_port;
      mode <= next_mode;
      fault_interrupt_mask <= next_fault_interrupt_mask;
      dma_enable_bit <= next_dma_enable_bit;
      service_interrupt_bit <= next_service_interrupt_bit;
      fifo_mem <= next_fifo_mem;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      last_byte <= next_last_byte;
      irq_pulse <= next_irq_pulse;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    host_rdata = rdata;
    irq_out = irq_pulse;
    ctrl_lines.strobe = !line_control_port[0];
    ctrl_lines.autofeed = !line_control_port[1];
    ctrl_lines.initialise = line_control_port[2];
    ctrl_lines.select_in = !line_control_port[3];
    // mode 110 shows the last byte taken from the test fifo
    port_data_lines_out = (mode == EPP_MODE_TEST) ? last_byte : port_data_latch;
    port_data_lines_oe = !direction;
    port_mode = mode;
    port_reverse = direction;
    dma_request = dma_enable_bit && !service_interrupt_bit &&
      (direction ? !fifo_empty : !fifo_full) &&
      (mode == EPP_MODE_FIFO_STD || mode == EPP_MODE_ECP || mode == EPP_MODE_TEST);
  end
endmodule

// [bench/epp_chk_checker.sv]
// assertions on the parallel port register block ports
// assumes epp_pkg; bound into every epp_regs instance
`timescale 1ns/1ns
module epp_chk
  import epp_pkg::*;
#(
  parameter logic [2:0] IRQ_CODE = 3'h0,
  parameter logic [2:0] DMA_CODE = 3'h0
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [10:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  input wire logic [7:0] host_rdata,
  input wire logic dma_request,
  input wire logic irq_line_level,
  input wire epp_pkg::epp_status_t line_status,
  input wire epp_pkg::epp_ctrl_lines_t ctrl_lines,
  input wire logic [7:0] port_data_lines_out,
  input wire logic port_data_lines_oe,
  input wire logic link_tx_valid,
  input wire epp_pkg::epp_mode_t port_mode
);
  import epp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic wr;
  logic rd;
  assign wr = host_write_strobe && clk_en;
  assign rd = host_read_strobe && clk_en;
  data_latch_a: assert property (
    wr && host_addr == OFS_DATA && port_mode == EPP_MODE_STD
    |=> port_data_lines_out == $past(host_wdata)) else $error("data latch not driven");
  status_read_a: assert property (
    rd && host_addr == OFS_STATUS |=> host_rdata == {~$past(line_status.busy),
    $past(line_status.ack), $past(line_status.paper_error), $past(line_status.select),
    $past(line_status.fault), 3'h0}) else $error("status read wrong");
  ctrl_lines_a: assert property (
    wr && host_addr == OFS_CONTROL |=> ctrl_lines == {~$past(host_wdata[3]),
    $past(host_wdata[2]), ~$past(host_wdata[1]), ~$past(host_wdata[0])})
    else $error("control lines wrong");
  mode_write_a: assert property (
    wr && host_addr == OFS_EXT_CTRL && port_mode inside {EPP_MODE_STD, EPP_MODE_BIDIR}
    |=> port_mode == $past(host_wdata[7:5])) else $error("mode not taken");
  out_drive_a: assert property (
    port_mode inside {EPP_MODE_STD, EPP_MODE_FIFO_STD} |-> port_data_lines_oe)
    else $error("data lines not driven");
  cfg_a_read_a: assert property (
    rd && host_addr == OFS_FIFO && port_mode == EPP_MODE_CFG |=> host_rdata == CFG_A_VALUE)
    else $error("config a wrong");
  cfg_b_read_a: assert property (
    rd && host_addr == OFS_CFG_B && port_mode == EPP_MODE_CFG
    |=> host_rdata == {1'b0, $past(irq_line_level), IRQ_CODE, DMA_CODE})
    else $error("config b wrong");
  dma_mode_a: assert property (
    dma_request |-> port_mode inside {EPP_MODE_FIFO_STD, EPP_MODE_ECP, EPP_MODE_TEST})
    else $error("dma outside fifo modes");
  tx_mode_a: assert property (
    link_tx_valid |-> port_mode inside {EPP_MODE_FIFO_STD, EPP_MODE_ECP})
    else $error("handshake outside transfer modes");
endmodule
bind epp_regs epp_chk #(.IRQ_CODE(IRQ_CODE), .DMA_CODE(DMA_CODE)) chk (
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_write_strobe(host_write_strobe),
  .host_read_strobe(host_read_strobe), .host_rdata(host_rdata), .dma_request(dma_request),
  .irq_line_level(irq_line_level), .line_status(line_status), .ctrl_lines(ctrl_lines),
  .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe),
  .link_tx_valid(link_tx_valid), .port_mode(port_mode));

// [bench/epp_periph.sv]
// peripheral model: slow handshake sink and data line wire
// assumes the link_* handshake of epp_regs
`timescale 1ns/1ns
module epp_periph
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [8:0] link_tx_data,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  output logic [7:0] link_rx_data,
  output logic link_rx_valid,
  input wire logic link_rx_ready,
  input wire logic [7:0] lines_out,
  input wire logic lines_oe,
  output logic [7:0] lines_in,
  output logic [8:0] last_tx,
  output logic [7:0] tx_count
);
  logic [1:0] pace;
  logic [7:0] rx_sent;
  // accepts one byte every fourth cycle
  assign link_tx_ready = (pace == 2'h3);
  // offers ten numbered bytes, held until taken, once the lines turn around
  assign link_rx_valid = !lines_oe && rx_sent < 8'h0A;
  assign link_rx_data = 8'h80 + rx_sent;
  // undriven lines show the complement of the output latch
  assign lines_in = lines_oe ? lines_out : ~lines_out;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pace <= 2'h0;
      last_tx <= 9'h000;
      tx_count <= 8'h00;
      rx_sent <= 8'h00;
    end
    else
    begin
      pace <= pace + 2'h1;
      if (link_tx_valid && link_tx_ready)
      begin
        last_tx <= link_tx_data;
        tx_count <= tx_count + 8'h01;
      end
      if (link_rx_valid && link_rx_ready)
      begin
        rx_sent <= rx_sent + 8'h01;
      end
    end
  end
endmodule

// [bench/epp_regs_tb.sv]
// self-checking bench for epp_regs
// assumes epp_pkg, epp_periph and the bound checker
`timescale 1ns/1ns
module epp_regs_tb;
  import epp_pkg::*;
  logic core_clk, rst_b, host_write_strobe, host_read_strobe, irq_out, irq_line_level;
  logic [10:0] host_addr;
  logic [7:0] host_wdata, host_rdata, lines_in, lines_out, rx_data, tx_count;
  logic dma_request, lines_oe, tx_valid, tx_ready, rx_valid;
  logic clk_en, dma_ack, dma_tc, rev, rx_ready;
  logic [8:0] tx_data, last_tx;
  epp_status_t line_status;
  epp_ctrl_lines_t ctrl_lines;
  epp_mode_t port_mode;
  int fail_count, samples_checked, cycles, irq_seen, n;
  epp_regs dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_write_strobe(host_write_strobe),
    .host_read_strobe(host_read_strobe), .host_rdata(host_rdata), .dma_ack(dma_ack),
    .dma_terminal_count(dma_tc), .dma_request(dma_request), .irq_out(irq_out),
    .irq_line_level(irq_line_level), .line_status(line_status), .ctrl_lines(ctrl_lines),
    .port_data_lines_in(lines_in), .port_data_lines_out(lines_out),
    .port_data_lines_oe(lines_oe), .link_tx_data(tx_data), .link_tx_valid(tx_valid),
    .link_tx_ready(tx_ready), .link_rx_data(rx_data), .link_rx_valid(rx_valid),
    .link_rx_ready(rx_ready), .port_mode(port_mode), .port_reverse(rev));
  epp_periph periph (.core_clk(core_clk), .rst_b(rst_b), .link_tx_data(tx_data),
    .link_tx_valid(tx_valid), .link_tx_ready(tx_ready), .link_rx_data(rx_data),
    .link_rx_valid(rx_valid), .link_rx_ready(rx_ready), .lines_out(lines_out),
    .lines_oe(lines_oe),
    .lines_in(lines_in), .last_tx(last_tx), .tx_count(tx_count));
  // ****
  // tasks
  // ****
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_addr = a;
    host_wdata = d;
    host_write_strobe = 1'b1;
    @(negedge core_clk);
    host_write_strobe = 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e,
    input string nm);
    @(negedge core_clk);
    host_addr = a;
    host_read_strobe = 1'b1;
    @(negedge core_clk);
    host_read_strobe = 1'b0;
    check(nm, {1'b0, host_rdata & m}, {1'b0, e});
  endtask
  task automatic edge_pair(input bit on_ack);
    @(negedge core_clk);
    if (on_ack) line_status.ack = 1'b0; else line_status.fault = 1'b1;
    repeat (3) @(negedge core_clk);
    if (on_ack) line_status.ack = 1'b1; else line_status.fault = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic wait_tx(input logic [7:0] c);
    for (int k = 0; k < 60 && tx_count !== c; k++)
      @(negedge core_clk);
  endtask
  task automatic dma_xfer(input logic [7:0] d, input logic tc);
    @(negedge core_clk);
    host_wdata = d;
    dma_ack = 1'b1;
    dma_tc = tc;
    @(negedge core_clk);
    dma_ack = 1'b0;
    dma_tc = 1'b0;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
  begin
    cycles++;
    if (irq_out === 1'b1)
      irq_seen++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ****
  // sequence
  // ****
  initial
  begin
    rst_b = 1'b0;
    host_addr = 11'h000;
    host_wdata = 8'h00;
    host_write_strobe = 1'b0;
    host_read_strobe = 1'b0;
    irq_line_level = 1'b1;
    clk_en = 1'b1;
    dma_ack = 1'b0;
    dma_tc = 1'b0;
    line_status = 5'h0B;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    check("ctrl lines", ctrl_lines, 9'h00B);
    rd(OFS_CONTROL, 8'hFF, 8'h00, "control");
    rd(OFS_DATA, 8'hFF, 8'h00, "data");
    clk_en = 1'b0;
    wr(OFS_CONTROL, 8'h01);
    clk_en = 1'b1;
    rd(OFS_CONTROL, 8'hFF, 8'h00, "frozen control");
    wr(OFS_CONTROL, 8'hFF);
    rd(OFS_CONTROL, 8'hFF, 8'h3F, "control");
    check("ctrl lines", ctrl_lines, 9'h004);
    wr(OFS_DATA, 8'hA5);
    rd(OFS_DATA, 8'hFF, 8'hA5, "data");
    wr(OFS_CONTROL, 8'h10);
    n = irq_seen;
    edge_pair(1'b1);
    check("ack irq", 9'(irq_seen - n), 9'h001);
    wr(OFS_CONTROL, 8'h00);
    n = irq_seen;
    edge_pair(1'b1);
    check("ack irq", 9'(irq_seen - n), 9'h000);
    for (int i = 0; i < 4; i++)
    begin
      line_status = 5'(i * 11);
      rd(OFS_STATUS, 8'hFF, {~line_status.busy, line_status[3:0], 3'h0}, "status");
    end
    line_status = 5'h0B;
    wr(OFS_EXT_CTRL, 8'hD4);
    for (int i = 0; i < 17; i++)
      wr(OFS_FIFO, 8'h40 + 8'(i));
    rd(OFS_EXT_CTRL, 8'h03, 8'h02, "full flag");
    for (int i = 0; i < 16; i++)
      rd(OFS_FIFO, 8'hFF, 8'h40 + 8'(i), "test fifo");
    rd(OFS_EXT_CTRL, 8'h03, 8'h01, "empty flag");
    rd(OFS_FIFO, 8'hFF, 8'h4F, "reread");
    wr(OFS_EXT_CTRL, 8'hD0);
    rd(OFS_EXT_CTRL, 8'h04, 8'h04, "service bit");
    wr(OFS_EXT_CTRL, 8'h14);
    wr(OFS_EXT_CTRL, 8'hF4);
    wr(OFS_FIFO, 8'h00);
    rd(OFS_FIFO, 8'hFF, 8'h10, "config a");
    rd(OFS_CFG_B, 8'hFF, 8'h40, "config b");
    wr(OFS_EXT_CTRL, 8'h14);
    wr(OFS_EXT_CTRL, 8'h34);
    wr(OFS_EXT_CTRL, 8'h74);
    wr(OFS_DATA, 8'h3C);
    wait_tx(8'h01);
    check("tagged byte", last_tx, 9'h13C);
    wr(OFS_FIFO, 8'h5A);
    wait_tx(8'h02);
    check("data byte", last_tx, 9'h05A);
    wr(OFS_EXT_CTRL, 8'h64);
    n = irq_seen;
    edge_pair(1'b0);
    wr(OFS_EXT_CTRL, 8'h74);
    edge_pair(1'b0);
    wr(OFS_EXT_CTRL, 8'h64);
    repeat (4) @(negedge core_clk);
    check("fault irq", 9'(irq_seen - n), 9'h002);
    line_status = 5'h0B;
    wr(OFS_EXT_CTRL, 8'h34);
    wr(OFS_EXT_CTRL, 8'hCC);
    check("dma blocked", dma_request, 9'h000);
    wr(OFS_EXT_CTRL, 8'hC8);
    check("dma request", dma_request, 9'h001);
    n = irq_seen;
    dma_xfer(8'h61, 1'b0);
    dma_xfer(8'h62, 1'b1);
    repeat (2) @(negedge core_clk);
    check("tc irq", 9'(irq_seen - n), 9'h001);
    check("dma after tc", dma_request, 9'h000);
    rd(OFS_EXT_CTRL, 8'h0F, 8'h0C, "tc service");
    rd(OFS_FIFO, 8'hFF, 8'h61, "dma fifo");
    rd(OFS_FIFO, 8'hFF, 8'h62, "dma fifo");
    wr(OFS_EXT_CTRL, 8'h34);
    wr(OFS_CONTROL, 8'h20);
    check("reverse oe", lines_oe, 9'h000);
    check("reverse flag", rev, 9'h001);
    wr(OFS_EXT_CTRL, 8'h60);
    repeat (12) @(negedge core_clk);
    rd(OFS_EXT_CTRL, 8'h07, 8'h04, "rx service");
    for (int i = 0; i < 10; i++)
      rd(OFS_FIFO, 8'hFF, 8'h80 + 8'(i), "rx fifo");
    rd(OFS_EXT_CTRL, 8'h03, 8'h01, "rx empty");
    wr(OFS_EXT_CTRL, 8'h34);
    wr(OFS_EXT_CTRL, 8'h54);
    check("fifo mode oe", lines_oe, 9'h001);
    check("fifo mode dir", rev, 9'h000);
    wr(OFS_FIFO, 8'hC3);
    wait_tx(8'h03);
    check("std fifo byte", last_tx, 9'h0C3);
    finish_test();
  end
endmodule
